// ---- include/tfc_pkg.sv ----
// Package for the serial transmit frame configuration block: map, layouts, state, coders.
package tfc_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0]  TFC_ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  TFC_ADDR_STAT   = 8'h04;
  // Control register reset value and the mask of bits that software can write.
  localparam logic [31:0] TFC_CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] TFC_CTRL_WMASK  = 32'hFFFF_7FF0;
  // Status register bit positions.
  localparam int          TFC_STAT_BUSY   = 0;
  localparam int          TFC_STAT_PHASE2 = 1;
  localparam int          TFC_STAT_UNDER  = 2;
  // AXI response codes.
  localparam logic [1:0]  TFC_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  TFC_RESP_SLVERR = 2'h2;

  // Word-length codes.
  localparam logic [2:0]  TFC_WL_8        = 3'h0;
  localparam logic [2:0]  TFC_WL_12       = 3'h1;
  localparam logic [2:0]  TFC_WL_16       = 3'h2;
  localparam logic [2:0]  TFC_WL_20       = 3'h3;
  localparam logic [2:0]  TFC_WL_24       = 3'h4;
  localparam logic [2:0]  TFC_WL_32       = 3'h5;
  localparam logic [5:0]  TFC_BITS_32     = 6'h20;
  // Companding codes.
  localparam logic [1:0]  TFC_CMP_MSB     = 2'h0;
  localparam logic [1:0]  TFC_CMP_LSB     = 2'h1;
  localparam logic [1:0]  TFC_CMP_MU      = 2'h2;
  localparam logic [1:0]  TFC_CMP_A       = 2'h3;
  // First-bit delay codes.
  localparam logic [1:0]  TFC_DLY_NONE    = 2'h0;
  localparam logic [1:0]  TFC_DLY_RSVD    = 2'h3;
  localparam logic [1:0]  TFC_DLY_MAX     = 2'h2;
  // Companding coder constants.
  localparam logic [13:0] TFC_MU_CLIP     = 14'h1FDE;
  localparam logic [13:0] TFC_MU_BIAS     = 14'h0021;
  localparam logic [12:0] TFC_A_CLIP      = 13'h0FFF;
  localparam logic [7:0]  TFC_A_XOR       = 8'h55;

  // Layout of the transmit frame control register, bit 31 first.
  typedef struct packed {
    logic       tx_dual_phase_select;
    logic [6:0] tx_phase2_word_count;
    logic [2:0] tx_phase2_word_bits;
    logic [1:0] tx_compand_select;
    logic       tx_late_sync_ignore;
    logic [1:0] tx_first_bit_delay;
    logic       rsvd15;
    logic [6:0] tx_phase1_word_count;
    logic [2:0] tx_phase1_word_bits;
    logic       tx_word_bit_reverse;
    logic [3:0] rsvd3_0;
  } tfc_ctrl_t;

  // Transmit engine states.
  typedef enum logic [1:0] {
    TFC_IDLE  = 2'b00,
    TFC_DELAY = 2'b01,
    TFC_SHIFT = 2'b10
  } tfc_state_t;

  // Whole state of the block.
  typedef struct packed {
    tfc_state_t       state;
    logic             phase2;
    logic [6:0]       word_cnt;
    logic [5:0]       bit_cnt;
    logic [5:0]       nbits;
    logic             lsb_first;
    logic [1:0]       dly_cnt;
    logic [31:0]      shreg;
    logic             dx;
    logic             fs_meta;
    logic             fs_sync;
    logic             fs_prev;
    logic             fs_pend;
    logic [7:0]       div_cnt;
    logic [1:0][31:0] fifo;
    logic             rd_ptr;
    logic             wr_ptr;
    logic [1:0]       count;
    tfc_ctrl_t        ctrl;
    logic             underrun;
    logic             aw_got;
    logic             w_got;
    logic [7:0]       awaddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } tfc_regs_t;

  localparam tfc_regs_t TFC_REGS_RESET = '0;

  // Word-length code to bit count; reserved codes fall back to 8 bits.
  function automatic logic [5:0] tfc_word_bits(input logic [2:0] code);
    unique case (code)
      TFC_WL_12: return 6'h0C;
      TFC_WL_16: return 6'h10;
      TFC_WL_20: return 6'h14;
      TFC_WL_24: return 6'h18;
      TFC_WL_32: return TFC_BITS_32;
      default:   return 6'h08;
    endcase
  endfunction

  // Mu-law compression of a 16-bit two's complement sample.
  function automatic logic [7:0] tfc_mu_encode(input logic [15:0] x);
    logic [15:0] mag;
    logic [13:0] b;
    logic [2:0]  seg;
    logic [13:0] sh;
    mag = x[15] ? 16'(-x) : x;
    b   = (mag[15:2] > TFC_MU_CLIP) ? TFC_MU_CLIP : mag[15:2];
    b   = 14'(b + TFC_MU_BIAS);
    seg = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (b[i + 5]) seg = 3'(i);
    end
    sh = b >> (4'(seg) + 4'h1);
    return ~{x[15], seg, sh[3:0]};
  endfunction

  // A-law compression of a 16-bit two's complement sample.
  function automatic logic [7:0] tfc_a_encode(input logic [15:0] x);
    logic [15:0] mag;
    logic [12:0] m;
    logic [2:0]  seg;
    logic [12:0] sh;
    mag = x[15] ? 16'(-x) : x;
    m   = (mag[15:3] > TFC_A_CLIP) ? TFC_A_CLIP : mag[15:3];
    seg = 3'h0;
    for (int i = 1; i < 8; i++) begin
      if (m[i + 4]) seg = 3'(i);
    end
    sh = (seg == 3'h0) ? (m >> 1) : (m >> seg);
    return {~x[15], seg, sh[3:0]} ^ TFC_A_XOR;
  endfunction

endpackage

// ---- design/tfc_transmit.sv ----
// Serial transmit frame engine with its frame control register on AXI4-Lite.
// Overview of operation
// [R1] Bit 31 picks one or two phases.
// [R2] Phase 1 sends count field plus one words.
// [R3] Phase 2 word bits from bits 23..21.
// [R4] Phase 1 word bits from bits 7..5.
// [R5] Word codes 0..5 give 8..32 bits.
// [R6] Companding only when word length is 8.
// [R7] Compand 0 MSB first, 2 mu, 3 A.
// [R8] Compand 1 sends 8 bits LSB first.
// [R9] Bit 18 restarts or ignores later syncs.
// [R10] First data bit delayed 0, 1, 2 bits.
// [R11] Reserved bits read zero, writes ignored.
// [R12] Bit 4 sends 32-bit words LSB first.
// [R13] Software pairs reversal with 32-bit, compand 1.
// [R14] Single phase ignores phase 2 fields.
module tfc_transmit
  import tfc_pkg::*;
#(
  parameter logic [7:0] CLK_DIV = 8'h04
) (
  // Clock and synchronous reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address and data.
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Transmit word stream from the system side.
  input  wire logic [31:0] tx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  // Serial pins toward the external device.
  input  wire logic        fsx_in,
  output logic             dx_out,
  output logic             dx_oe,
  output logic             frame_active
);

  tfc_regs_t r;       // Registered state.
  tfc_regs_t next_r;  // Next state.

  // Combinational handshakes straight from the state.
  assign s_axi_awready = !r.aw_got && !r.bvalid;
  assign s_axi_wready  = !r.w_got && !r.bvalid;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;
  // The two-entry buffer accepts while it has a free slot.
  assign tx_ready      = (r.count != 2'h2);
  // Data comes from a flip-flop and the enable is decoded from the state register; the pin is driven only while bits shift.
  assign dx_out        = r.dx;
  assign dx_oe         = (r.state == TFC_SHIFT);
  assign frame_active  = (r.state != TFC_IDLE);

  // Next-state logic for the bus slave, the buffer and the serial engine.
  always_comb begin
    logic        tick;         // One-cycle bit-rate enable.
    logic        start;        // A frame begins at this tick.
    logic        do_load;      // A new word is taken at this tick.
    logic        ld_p2;        // The new word belongs to phase 2.
    logic        pop;          // The buffer gives up its oldest word.
    logic [2:0]  wl_code;      // Word-length code of the loaded phase.
    logic [1:0]  cmp;          // Effective companding of the loaded phase.
    logic [31:0] word;         // Word as taken from the buffer.
    logic [31:0] aligned;      // Word placed for its shift direction.
    logic [31:0] wr_val;       // Control value after byte strobes.
    logic        w_ctrl;       // Register write hits the control word.
    logic        w_stat;       // Register write hits the status word.
    logic [1:0]  dly_eff;      // First-bit delay with the reserved code clamped.
    tick    = 1'b0;
    start   = 1'b0;
    do_load = 1'b0;
    ld_p2   = 1'b0;
    pop     = 1'b0;
    wl_code = TFC_WL_8;
    cmp     = TFC_CMP_MSB;
    word    = '0;
    aligned = '0;
    wr_val  = r.ctrl;
    w_ctrl  = 1'b0;
    w_stat  = 1'b0;
    dly_eff = r.ctrl.tx_first_bit_delay;
    next_r  = r;

    // The sync pin crosses in two flops; only the second flop feeds the edge detector.
    next_r.fs_meta = fsx_in;
    next_r.fs_sync = r.fs_meta;
    next_r.fs_prev = r.fs_sync;
    if (r.fs_sync && !r.fs_prev) begin
      next_r.fs_pend = 1'b1;
    end

    // Bit-rate divider: the engine moves only on its enable pulse.
    if (r.div_cnt == 8'(CLK_DIV - 8'h01)) begin
      tick           = 1'b1;
      next_r.div_cnt = '0;
    end else begin
      next_r.div_cnt = 8'(r.div_cnt + 8'h01);
    end

    // Reserved delay code is treated as the longest legal delay.
    if (dly_eff == TFC_DLY_RSVD) begin
      dly_eff = TFC_DLY_MAX;
    end

    // Serial engine, advanced once per bit period.
    if (tick) begin
      // A pending edge is consumed now; an edge found in this same cycle stays pending.
      next_r.fs_pend = r.fs_sync && !r.fs_prev;
      // [R9] restart or ignore
      start = r.fs_pend && ((r.state == TFC_IDLE) || !r.ctrl.tx_late_sync_ignore);
      if (start) begin
        next_r.phase2   = 1'b0;
        next_r.word_cnt = '0;
        // [R10] first-bit delay
        if (dly_eff == TFC_DLY_NONE) begin
          do_load = 1'b1;
        end else begin
          next_r.state   = TFC_DELAY;
          next_r.dly_cnt = dly_eff;
          next_r.dx      = 1'b0;
        end
      end else begin
        unique case (r.state)
          // Nothing to send until the next frame sync.
          TFC_IDLE: begin
            next_r.dx = 1'b0;
          end
          // Count out the delay bits, then send the first word.
          TFC_DELAY: begin
            if (r.dly_cnt == 2'h1) begin
              do_load = 1'b1;
            end else begin
              next_r.dly_cnt = 2'(r.dly_cnt - 2'h1);
            end
          end
          // Shift the current word, then pick the next word or phase.
          TFC_SHIFT: begin
            if (r.bit_cnt == 6'(r.nbits - 6'h01)) begin
              // [R2] phase 1 word count
              if (!r.phase2 && (r.word_cnt != r.ctrl.tx_phase1_word_count)) begin
                next_r.word_cnt = 7'(r.word_cnt + 7'h01);
                do_load         = 1'b1;
              // [R1] second phase
              end else if (!r.phase2 && r.ctrl.tx_dual_phase_select) begin
                next_r.phase2   = 1'b1;
                next_r.word_cnt = '0;
                ld_p2           = 1'b1;
                do_load         = 1'b1;
              // [R1] phase 2 word count
              end else if (r.phase2 && (r.word_cnt != r.ctrl.tx_phase2_word_count)) begin
                next_r.word_cnt = 7'(r.word_cnt + 7'h01);
                ld_p2           = 1'b1;
                do_load         = 1'b1;
              end else begin
                // [R14] single phase ends here
                next_r.state  = TFC_IDLE;
                next_r.phase2 = 1'b0;
                next_r.dx     = 1'b0;
              end
            end else begin
              next_r.bit_cnt = 6'(r.bit_cnt + 6'h01);
              if (r.lsb_first) begin
                next_r.dx    = r.shreg[0];
                next_r.shreg = r.shreg >> 1;
              end else begin
                next_r.dx    = r.shreg[31];
                next_r.shreg = r.shreg << 1;
              end
            end
          end
          default: begin
            next_r.state = TFC_IDLE;
          end
        endcase
      end
    end

    // Word load: take the oldest buffered word, or use a zero sample on underrun.
    if (do_load) begin
      if (ld_p2) begin
        // [R3] phase 2 word bits
        wl_code = r.ctrl.tx_phase2_word_bits;
      end else begin
        // [R4] phase 1 word bits
        wl_code = r.ctrl.tx_phase1_word_bits;
      end
      // [R6] companding needs 8-bit words
      cmp = (wl_code == TFC_WL_8) ? r.ctrl.tx_compand_select : TFC_CMP_MSB;
      if (r.count != 2'h0) begin
        word = r.fifo[r.rd_ptr];
        pop  = 1'b1;
      end else begin
        next_r.underrun = 1'b1;
      end
      // [R5] word-length decode
      next_r.nbits   = tfc_word_bits(wl_code);
      next_r.bit_cnt = '0;
      next_r.state   = TFC_SHIFT;
      // [R12] 32-bit reversal; [R8] LSB-first 8-bit
      next_r.lsb_first = (cmp == TFC_CMP_LSB) ||
                         (r.ctrl.tx_word_bit_reverse && (wl_code == TFC_WL_32));
      // [R7] mu-law and A-law
      if (cmp == TFC_CMP_MU) begin
        word = {24'h000000, tfc_mu_encode(word[15:0])};
      end else if (cmp == TFC_CMP_A) begin
        word = {24'h000000, tfc_a_encode(word[15:0])};
      end
      if (next_r.lsb_first) begin
        next_r.dx    = word[0];
        next_r.shreg = word >> 1;
      end else begin
        aligned      = word << (TFC_BITS_32 - next_r.nbits);
        next_r.dx    = aligned[31];
        next_r.shreg = aligned << 1;
      end
    end

    // Two-entry buffer: a stalled engine fills it and tx_ready drops.
    if (tx_valid && (r.count != 2'h2)) begin
      next_r.fifo[r.wr_ptr] = tx_data;
      next_r.wr_ptr         = !r.wr_ptr;
    end
    if (pop) begin
      next_r.rd_ptr = !r.rd_ptr;
    end
    next_r.count = 2'(r.count + {1'b0, tx_valid && (r.count != 2'h2)} - {1'b0, pop});

    // Write address and data are taken independently and held until both are in.
    if (s_axi_awvalid && !r.aw_got && !r.bvalid) begin
      next_r.aw_got = 1'b1;
      next_r.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.w_got && !r.bvalid) begin
      next_r.w_got = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    if (r.aw_got && r.w_got && !r.bvalid) begin
      w_ctrl = ({r.awaddr[7:2], 2'b00} == TFC_ADDR_CTRL);
      w_stat = ({r.awaddr[7:2], 2'b00} == TFC_ADDR_STAT);
      for (int b = 0; b < 4; b++) begin
        if (r.wstrb[b]) wr_val[b*8 +: 8] = r.wdata[b*8 +: 8];
      end
      if (w_ctrl) begin
        // [R11] reserved bits stay zero
        next_r.ctrl = tfc_ctrl_t'(wr_val & TFC_CTRL_WMASK);
      end
      // Underrun clears by writing one; a same-cycle new underrun wins.
      if (w_stat && r.wstrb[0] && r.wdata[TFC_STAT_UNDER] && !(do_load && !pop)) begin
        next_r.underrun = 1'b0;
      end
      next_r.bresp  = (w_ctrl || w_stat) ? TFC_RESP_OKAY : TFC_RESP_SLVERR;
      next_r.bvalid = 1'b1;
      next_r.aw_got = 1'b0;
      next_r.w_got  = 1'b0;
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end

    // Reads answer one cycle after the address is taken.
    if (s_axi_arvalid && !r.rvalid) begin
      next_r.rvalid = 1'b1;
      next_r.rresp  = TFC_RESP_OKAY;
      next_r.rdata  = '0;
      if ({s_axi_araddr[7:2], 2'b00} == TFC_ADDR_CTRL) begin
        next_r.rdata = r.ctrl;
      end else if ({s_axi_araddr[7:2], 2'b00} == TFC_ADDR_STAT) begin
        next_r.rdata[TFC_STAT_BUSY]   = (r.state != TFC_IDLE);
        next_r.rdata[TFC_STAT_PHASE2] = r.phase2;
        next_r.rdata[TFC_STAT_UNDER]  = r.underrun;
      end else begin
        next_r.rresp = TFC_RESP_SLVERR;
      end
    end else if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
  end

  // State register with synchronous reset to constants only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= TFC_REGS_RESET;
    end else begin
      r <= next_r;
    end
  end

endmodule // tfc_transmit

// ---- tb/tfc_transmit_sva.sv ----
// Checker for the bus handshakes and serial pins of the transmit block.
module tfc_transmit_sva
  import tfc_pkg::*;
(
  // Clock and reset.
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus.
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Stream and serial pins.
  input wire logic        tx_ready,
  input wire logic        dx_out,
  input wire logic        dx_oe,
  input wire logic        frame_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Handshakes are open right after reset.
  rst_ready_a: assert property ($rose(aresetn) |-> s_axi_arready && tx_ready)
    else $error("ready low after reset");
  // A write taken whole is applied one cycle later and answered the cycle after.
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid) else $error("write response late");
  // A pending response blocks new write halves.
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  // The write response stands until accepted.
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  // A read is answered on the next cycle.
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  // The read data stand until accepted.
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rsvd_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h00
    |=> s_axi_rdata[15] == 1'b0 && s_axi_rdata[3:0] == 4'h0) else $error("reserved bits set");
  line_idle_a: assert property (!frame_active |-> !dx_oe && !dx_out)
    else $error("line driven outside frame");
  // The first bit lasts a whole bit period of at least two cycles.
  first_bit_a: assert property ($rose(dx_oe) |=> dx_oe && $stable(dx_out))
    else $error("first bit too short");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property ($rose(frame_active) ##1 !dx_oe);
  cover property ($fell(tx_ready));
endmodule  // tfc_transmit_sva

// ---- tb/tfc_serial_peer.sv ----
// Behavioural far-end serial device: frame sync source and bit capture.
module tfc_serial_peer
  import tfc_pkg::*;
#(
  parameter int CLK_DIV = 2
) (
  // Clock and bench controls.
  input  wire logic   aclk,
  input  wire logic   go,
  input  wire logic   clr,
  // Serial pins.
  output logic        fsx_in,
  input  wire logic   dx_out,
  input  wire logic   dx_oe,
  input  wire logic   frame_active,
  // Captured frame.
  output logic [127:0] rx_sh,
  output logic [7:0]  rx_cnt,
  output logic [7:0]  dly_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] fs_hold = 2'h0;  // Cycles left in the sync pulse.
  int         ph      = 0;     // Phase within one bit period.

  // Sync pulse of two cycles; bits taken once a period, first cycle after each change.
  always @(posedge aclk) begin
    fs_hold <= go ? 2'h2 : (fs_hold != 2'h0 ? fs_hold - 2'h1 : 2'h0);
    fsx_in <= go || fs_hold > 2'h1;
    if (clr) begin
      rx_sh <= '0;
      rx_cnt <= 8'h00;
      dly_cnt <= 8'h00;
    end else begin
      if (frame_active && !dx_oe) dly_cnt <= dly_cnt + 8'h01;
      if (dx_oe && ph == 0) begin
        rx_sh <= {rx_sh[126:0], dx_out};
        rx_cnt <= rx_cnt + 8'h01;
      end
    end
    ph <= dx_oe ? (ph + 1) % CLK_DIV : 0;
  end
endmodule  // tfc_serial_peer

// ---- tb/tb_serial_transmit_frame_config.sv ----
// Self-checking bench for the transmit frame engine and its control register.
module tb_serial_transmit_frame_config
  import tfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 2;  // Short bit period keeps frames brief.
  logic         aclk, aresetn, go, clr, fsx, dx_out, dx_oe, frame_active;
  logic [7:0]   awaddr, araddr, rx_cnt, dly_cnt;
  logic [31:0]  wdata, rdata, tx_data;
  logic [3:0]   wstrb;
  logic [1:0]   bresp, rresp;
  logic         awvalid, awready, wvalid, wready, bvalid, bready;
  logic         arvalid, arready, rvalid, rready, tx_valid, tx_ready;
  logic [127:0] rx_sh;
  logic [31:0]  feed_q[$];  // Words waiting to enter the stream.
  int           n_fail, samples_checked, cycles, seed;

  tfc_transmit #(.CLK_DIV(8'(DIV))) i_tfc_transmit (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .fsx_in(fsx),
    .dx_out(dx_out), .dx_oe(dx_oe), .frame_active(frame_active));
  tfc_serial_peer #(.CLK_DIV(DIV)) i_tfc_serial_peer (.aclk(aclk), .go(go), .clr(clr),
    .fsx_in(fsx), .dx_out(dx_out), .dx_oe(dx_oe), .frame_active(frame_active),
    .rx_sh(rx_sh), .rx_cnt(rx_cnt), .dly_cnt(dly_cnt));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Hang guard: far above the few thousand cycles the tests need.
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // Stream feeder: offers the front word until the block takes it.
  always @(posedge aclk) begin
    if (tx_valid && tx_ready) void'(feed_q.pop_front());
    tx_valid <= feed_q.size() > 0;
    tx_data <= (feed_q.size() > 0) ? feed_q[0] : 32'h0;
  end

  task automatic check(input logic [127:0] seen, input logic [127:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_fail++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, want);
    end
  endtask

  task automatic tally_and_finish;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Both write halves go out together; each is dropped once taken.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1) begin aw_done = 1; awvalid <= 1'b0; end
      if (!w_done && wready === 1'b1) begin w_done = 1; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask

  function automatic int rnd(input int n);
    return {$random(seed)} % n;
  endfunction

  // Control word built field by field, bit 31 first, reserved places zero.
  function automatic tfc_ctrl_t mk(input int dual, cnt2, wl2, cmp, fig, dly, cnt1, wl1, rev);
    return tfc_ctrl_t'({1'(dual), 7'(cnt2), 3'(wl2), 2'(cmp), 1'(fig), 2'(dly), 1'b0,
                        7'(cnt1), 3'(wl1), 1'(rev), 4'h0});
  endfunction

  function automatic int word_bits(input logic [2:0] code);
    case (code)
      3'h1: return 12;
      3'h2: return 16;
      3'h3: return 20;
      3'h4: return 24;
      3'h5: return 32;
      default: return 8;
    endcase
  endfunction

  // Serial stream expected for one frame; companded words assume a zero sample.
  function automatic logic [127:0] frame_bits(input tfc_ctrl_t c, input logic [31:0] w[$],
                                              output int total);
    logic [127:0] acc;
    logic [31:0]  v;
    int           n;
    acc = '0;
    total = 0;
    foreach (w[i]) begin
      n = word_bits(i > c.tx_phase1_word_count ? c.tx_phase2_word_bits : c.tx_phase1_word_bits);
      v = w[i];
      if (n == 8 && c.tx_compand_select == TFC_CMP_MU) v = 32'hFF;
      if (n == 8 && c.tx_compand_select == TFC_CMP_A) v = 32'hD5;
      if ((n == 8 && c.tx_compand_select == TFC_CMP_LSB) || (n == 32 && c.tx_word_bit_reverse))
        v = {<<{32'(v << (32 - n))}};
      acc = (acc << n) | 128'(v & ~(32'hFFFFFFFF << n));
      total += n;
    end
    return acc;
  endfunction

  task automatic pulse(input logic clear);
    clr <= clear;
    go <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    go <= 1'b0;
  endtask

  task automatic wait_frame;
    @(posedge aclk iff frame_active === 1'b1);
    @(posedge aclk iff frame_active === 1'b0);
  endtask

  task automatic run_frame(input tfc_ctrl_t c);
    logic [31:0]  w[$];
    logic [127:0] want;
    logic [1:0]   r;
    int           total, nw;
    nw = c.tx_phase1_word_count + 1 + (c.tx_dual_phase_select ? c.tx_phase2_word_count + 1 : 0);
    for (int i = 0; i < nw; i++) w.push_back($random(seed) & (c.tx_compand_select[1] ?
                                              32'hFFFF0000 : 32'hFFFFFFFF));
    want = frame_bits(c, w, total);
    axi_write(TFC_ADDR_CTRL, c, r);
    feed_q = w;
    repeat (6) @(posedge aclk);
    // With no frame running, two words fill the buffer and it refuses more.
    check(tx_ready, w.size() < 2);
    pulse(1'b1);
    wait_frame();
    check(rx_cnt, total);
    check(rx_sh, want);
    check(dly_cnt, DIV * c.tx_first_bit_delay);
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    seed = 23624; aresetn = 1'b0; go = 1'b0; clr = 1'b0; awvalid = 1'b0; wvalid = 1'b0;
    bready = 1'b0; arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00;
    wdata = 32'h0; wstrb = 4'hF;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(TFC_ADDR_CTRL, d, r);
    check(d, TFC_CTRL_RESET);
    axi_write(TFC_ADDR_CTRL, 32'hFFFFFFFF, r);
    axi_read(TFC_ADDR_CTRL, d, r);
    check({r, d}, {TFC_RESP_OKAY, 32'hFFFF7FF0});
    axi_write(8'h08, 32'h0, r);
    check(r, TFC_RESP_SLVERR);
    axi_read(8'h08, d, r);
    check({r, d}, {TFC_RESP_SLVERR, 32'h0});
    axi_read(TFC_ADDR_CTRL, d, r);
    check(d, 32'hFFFF7FF0);
    run_frame(mk(0, 0, 0, 2, 0, 0, 0, 0, 0));
    run_frame(mk(0, 0, 0, 3, 0, 1, 0, 0, 0));
    // reversal set with both phases 32 bits and compand code 1
    run_frame(mk(1, 0, 5, 1, 0, 2, 1, 5, 1));
    for (int k = 0; k < 6; k++) run_frame(mk(1, 1, 5 - k, 1, 0, k % 3, 0, k, 0));
    // A second sync mid-frame restarts it only while ignoring is off.
    for (int f = 0; f < 2; f++) begin
      axi_write(TFC_ADDR_CTRL, mk(0, 0, 0, 0, f, 0, 0, 0, 0), r);
      feed_q = {32'hA5};
      if (!f) feed_q.push_back(32'h3C);
      repeat (4) @(posedge aclk);
      pulse(1'b1);
      repeat (8) @(posedge aclk);
      pulse(1'b0);
      wait_frame();
      check(rx_sh[7:0], f ? 8'hA5 : 8'h3C);
      check(rx_cnt == 8'h08, f);
    end
    repeat (12) run_frame(mk(rnd(2), rnd(2), rnd(6), rnd(2), rnd(2), rnd(3), rnd(2), rnd(6), 0));
    // A frame with an empty buffer must raise only the sticky underrun flag.
    pulse(1'b1);
    wait_frame();
    axi_read(TFC_ADDR_STAT, d, r);
    axi_write(TFC_ADDR_STAT, 32'h4, r);
    check(d, 32'h4);
    tally_and_finish();
  end
endmodule  // tb_serial_transmit_frame_config

bind tfc_transmit tfc_transmit_sva i_tfc_transmit_sva (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .tx_ready(tx_ready), .dx_out(dx_out), .dx_oe(dx_oe),
  .frame_active(frame_active));
